// *** rtl/lfr_ifs.sv ***
// stop sequencing link between control and stop unit
interface lfr_stop_if;
    logic act;
    logic held;
    logic clear;
    logic [1:0] action;
    logic stopping;
    logic coasting;
    modport ctl (output act, held, clear, action, input stopping, coasting);
    modport unit (input act, held, clear, action, output stopping, coasting);
endinterface

// two-source reference combiner link
interface lfr_ref_if
    import lfr_pkg::*;
;
    logic signed [REF_W-1:0] a;
    logic signed [REF_W-1:0] b;
    logic signed [REF_W-1:0] y;
    logic [3:0] mode;
    logic toggle;
    modport ctl (output a, b, mode, toggle, input y);
    modport unit (input a, b, mode, toggle, output y);
endinterface

// *** rtl/lfr_pkg.sv ***
// Notes on behaviour
// - force stop on: panel stop stops any place
// - force stop press also selects local control, except in local mode 2
// - local mode: 0 allow, 1 no start, 2 none
// - continue on: running state kept entering local
// - stop action 0 normal stop, 1 coast
// - action 2: stop, coast after 2 s hold
// - local speed reference from selected source 1-5
// - local torque reference from selected source 1-5
// - local process reference from selected source 1-5
// - fieldbus two speed sources, none gives zero
// - combine 0 source one, 1 source two
// - combine 2 sum, 3 one minus two
// - combine 4 divide, 5 multiply
// - combine 6 maximum, 7 minimum
// - combine 8 toggles sources by digital input
// - toggle input low first, high second source
// - place codes 1 local ... 4 advanced control
package lfr_pkg;
    localparam int REF_W = 16;
    localparam int NSRC = 5;
    localparam int SRC_BUS_W = REF_W * NSRC;

    // control place codes
    localparam logic [2:0] PLACE_LOCAL = 3'h1;
    localparam logic [2:0] PLACE_FB = 3'h2;
    localparam logic [2:0] PLACE_IO = 3'h3;
    localparam logic [2:0] PLACE_ADV = 3'h4;

    // reference source codes
    localparam logic [2:0] SRC_NONE = 3'h0;
    localparam logic [2:0] SRC_PANEL = 3'h1;
    localparam logic [2:0] SRC_PRESET = 3'h5;

    // local restriction and stop action codes
    localparam logic [1:0] MODE_ALLOW = 2'h0;
    localparam logic [1:0] MODE_DENY_START = 2'h1;
    localparam logic [1:0] MODE_DENY_CTRL = 2'h2;
    localparam logic [1:0] ACT_STOP = 2'h0;
    localparam logic [1:0] ACT_COAST = 2'h1;
    localparam logic [1:0] ACT_HOLD = 2'h2;

    // fieldbus speed combination codes
    localparam logic [3:0] COMB_SRC1 = 4'h0;
    localparam logic [3:0] COMB_SRC2 = 4'h1;
    localparam logic [3:0] COMB_SUM = 4'h2;
    localparam logic [3:0] COMB_SUB = 4'h3;
    localparam logic [3:0] COMB_DIV = 4'h4;
    localparam logic [3:0] COMB_MUL = 4'h5;
    localparam logic [3:0] COMB_MAX = 4'h6;
    localparam logic [3:0] COMB_MIN = 4'h7;
    localparam logic [3:0] COMB_TOGGLE = 4'h8;

    // register byte offsets
    localparam logic [11:0] ADDR_PLACE = 12'h000;
    localparam logic [11:0] ADDR_LCFG = 12'h004;
    localparam logic [11:0] ADDR_LSRC = 12'h008;
    localparam logic [11:0] ADDR_FBSPD = 12'h00c;
    localparam logic [11:0] ADDR_STATUS = 12'h010;

    // field positions
    localparam int PLACE_LSB = 0;
    localparam int LCFG_FORCE = 0;
    localparam int LCFG_MODE_LSB = 1;
    localparam int LCFG_CONT = 3;
    localparam int LCFG_ACT_LSB = 4;
    localparam int LSRC_SPD_LSB = 0;
    localparam int LSRC_TRQ_LSB = 4;
    localparam int LSRC_PROC_LSB = 8;
    localparam int FB_SRC1_LSB = 0;
    localparam int FB_SRC2_LSB = 4;
    localparam int FB_LOG_LSB = 8;
    localparam int STAT_RUN = 4;
    localparam int STAT_STOP = 5;
    localparam int STAT_COAST = 6;

    // values after reset
    localparam logic [2:0] RST_PLACE = 3'h4;
    localparam logic RST_FORCE = 1'b1;
    localparam logic [1:0] RST_MODE = 2'h0;
    localparam logic RST_CONT = 1'b1;
    localparam logic [1:0] RST_ACT = 2'h2;
    localparam logic [2:0] RST_LSRC = 3'h1;
    localparam logic [2:0] RST_FB1 = 3'h2;
    localparam logic [2:0] RST_FB2 = 3'h0;
    localparam logic [3:0] RST_FBLOG = 4'h0;

    // stop hold time
    localparam longint unsigned HOLD_TIME_S = 2;
    localparam longint unsigned CLK_FREQ_HZ = 200_000_000;
    localparam longint unsigned HOLD_CYC = HOLD_TIME_S * CLK_FREQ_HZ;

    typedef enum logic [1:0] {SU_IDLE, SU_STOP, SU_COAST} lfr_stop_st_t;
endpackage

// *** rtl/lfr_ref_comb.sv ***
module lfr_ref_comb
    import lfr_pkg::*;
(
    lfr_ref_if.unit rif
);
    logic signed [31:0] a_w, b_w, y_w;

    // clamp a wide result into the reference range
    function automatic logic signed [REF_W-1:0] sat_ref(input logic signed [31:0] v);
        if (v > 32'sh00007fff) begin
            return 16'sh7fff;
        end else if (v < 32'shffff8000) begin
            return 16'sh8000;
        end
        return v[REF_W-1:0];
    endfunction

    // source select, arithmetic, max/min or toggle combination of the two sources
    always_comb begin
        a_w = {{(32 - REF_W){rif.a[REF_W-1]}}, rif.a};
        b_w = {{(32 - REF_W){rif.b[REF_W-1]}}, rif.b};
        unique case (rif.mode)
            COMB_SRC1: y_w = a_w;
            COMB_SRC2: y_w = b_w;
            COMB_SUM: y_w = a_w + b_w;
            COMB_SUB: y_w = a_w - b_w;
            COMB_DIV: y_w = (b_w == 32'sh0) ? 32'sh0 : a_w / b_w;
            COMB_MUL: y_w = a_w * b_w;
            COMB_MAX: y_w = (a_w > b_w) ? a_w : b_w;
            COMB_MIN: y_w = (a_w < b_w) ? a_w : b_w;
            COMB_TOGGLE: y_w = rif.toggle ? b_w : a_w;
            default: y_w = 32'sh0;
        endcase
    end

    assign rif.y = sat_ref(y_w);
endmodule

// *** rtl/lfr_stop_unit.sv ***
module lfr_stop_unit
    import lfr_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES = 32'(HOLD_CYC)
) (
    input wire logic clk,
    input wire logic rst_n,
    lfr_stop_if.unit sif
);
    lfr_stop_st_t state_reg, state_next;
    logic [31:0] cnt_reg, cnt_next;
    logic stop_reg, stop_next, coast_reg, coast_next;

    // press picks stop or coast, hold timer upgrades stop to coast
    always_comb begin
        state_next = state_reg;
        cnt_next = 32'h0;
        if (sif.act) begin
            state_next = (sif.action == ACT_COAST) ? SU_COAST : SU_STOP;
        end else if (sif.clear) begin
            state_next = SU_IDLE;
        end else if (state_reg == SU_STOP && sif.action == ACT_HOLD && sif.held) begin
            if (cnt_reg >= HOLD_CYCLES - 32'h1) begin
                state_next = SU_COAST;
            end else begin
                cnt_next = cnt_reg + 32'h1;
            end
        end
        stop_next = (state_next == SU_STOP);
        coast_next = (state_next == SU_COAST);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= SU_IDLE;
            cnt_reg <= 32'h0;
            stop_reg <= 1'b0;
            coast_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            stop_reg <= stop_next;
            coast_reg <= coast_next;
        end
    end

    assign sif.stopping = stop_reg;
    assign sif.coasting = coast_reg;

    sequence s_held_stop;
        state_reg == SU_STOP && sif.action == ACT_HOLD && sif.held && !sif.act && !sif.clear;
    endsequence

    sequence s_hold_done;
        s_held_stop ##0 (cnt_reg == HOLD_CYCLES - 32'h1);
    endsequence

    a_hold_coast:
        assert property (@(posedge clk) disable iff (!rst_n)
            s_hold_done |=> coast_reg && !stop_reg)
        else $error("held stop did not turn into coast");

    a_release_stop:
        assert property (@(posedge clk) disable iff (!rst_n)
            state_reg == SU_STOP && !sif.held && !sif.act && !sif.clear |=> stop_reg && !coast_reg)
        else $error("released stop button changed the stop mode");

    a_press_stop:
        assert property (@(posedge clk) disable iff (!rst_n)
            sif.act && sif.action == ACT_STOP |=> stop_reg && !coast_reg)
        else $error("normal stop action not taken");

    a_press_coast:
        assert property (@(posedge clk) disable iff (!rst_n)
            sif.act && sif.action == ACT_COAST |=> coast_reg && !stop_reg)
        else $error("coast stop action not taken");
endmodule

// *** rtl/lfr_top.sv ***
module lfr_top
    import lfr_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES = 32'(HOLD_CYC)
) (
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic PANEL_STOP_BTN,
    input wire logic PANEL_START_BTN,
    input wire logic REMOTE_RUN,
    input wire logic FB_TOGGLE_IN,
    input wire logic [SRC_BUS_W-1:0] SPD_SRC_IN,
    input wire logic [SRC_BUS_W-1:0] TRQ_SRC_IN,
    input wire logic [SRC_BUS_W-1:0] PROC_SRC_IN,
    output logic RUN_CMD,
    output logic STOP_CMD,
    output logic COAST_CMD,
    output logic [2:0] ACTIVE_PLACE,
    output logic LOCAL_ACTIVE,
    output logic signed [REF_W-1:0] SPEED_REF,
    output logic signed [REF_W-1:0] TORQUE_REF,
    output logic signed [REF_W-1:0] PROCESS_REF
);
    logic pready_reg, pready_next, pslverr_reg, pslverr_next;
    logic [31:0] prdata_reg, prdata_next;
    logic force_reg, force_next, cont_reg, cont_next;
    logic [1:0] mode_reg, mode_next, act_reg, act_next;
    logic [2:0] lspd_reg, lspd_next, ltrq_reg, ltrq_next, lproc_reg, lproc_next;
    logic [2:0] fb1_reg, fb1_next, fb2_reg, fb2_next;
    logic [3:0] fblog_reg, fblog_next;
    logic [2:0] place_reg, place_next;
    logic local_reg, local_next;
    logic run_reg, run_next, stop_prev_reg, start_prev_reg;
    logic signed [REF_W-1:0] spd_reg, spd_next, trq_reg, trq_next, proc_reg, proc_next;
    logic setup, wr, hit;
    logic [31:0] rd_word;
    logic is_local, is_fb, stop_edge, start_edge, stop_acts, force_local, place_ok;
    logic enter_local;
    logic [2:0] place_req;
    logic signed [REF_W-1:0] panel_spd, panel_trq;

    lfr_stop_if sif ();
    lfr_ref_if rif ();

    // source code 1..5 picks one slice of a source bus, else zero
    function automatic logic signed [REF_W-1:0] pick_src(input logic [SRC_BUS_W-1:0] bus,
                                                          input logic [2:0] code);
        pick_src = '0;
        if (code >= SRC_PANEL && code <= SRC_PRESET) begin
            pick_src = bus[(int'(code) - 1) * REF_W +: REF_W];
        end
    endfunction

    // bus phase decode
    assign setup = PSEL & ~PENABLE;
    assign wr = PSEL & PENABLE & pready_reg & PWRITE;

    // read mux and address decode
    always_comb begin
        rd_word = 32'h0;
        hit = 1'b1;
        case (PADDR)
            ADDR_PLACE: rd_word[PLACE_LSB +: 3] = place_reg;
            ADDR_LCFG: begin
                rd_word[LCFG_FORCE] = force_reg;
                rd_word[LCFG_MODE_LSB +: 2] = mode_reg;
                rd_word[LCFG_CONT] = cont_reg;
                rd_word[LCFG_ACT_LSB +: 2] = act_reg;
            end
            ADDR_LSRC: begin
                rd_word[LSRC_SPD_LSB +: 3] = lspd_reg;
                rd_word[LSRC_TRQ_LSB +: 3] = ltrq_reg;
                rd_word[LSRC_PROC_LSB +: 3] = lproc_reg;
            end
            ADDR_FBSPD: begin
                rd_word[FB_SRC1_LSB +: 3] = fb1_reg;
                rd_word[FB_SRC2_LSB +: 3] = fb2_reg;
                rd_word[FB_LOG_LSB +: 4] = fblog_reg;
            end
            ADDR_STATUS: begin
                rd_word[PLACE_LSB +: 3] = place_reg;
                rd_word[STAT_RUN] = run_reg;
                rd_word[STAT_STOP] = sif.stopping;
                rd_word[STAT_COAST] = sif.coasting;
            end
            default: hit = 1'b0;
        endcase
    end

    // bus answer: ready in the access phase, data captured at setup
    always_comb begin
        pready_next = setup;
        prdata_next = prdata_reg;
        pslverr_next = pslverr_reg;
        if (setup) begin
            prdata_next = PWRITE ? 32'h0 : rd_word;
            pslverr_next = ~hit;
        end
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= pready_next;
            prdata_reg <= prdata_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // configuration registers
    always_comb begin
        force_next = force_reg;
        mode_next = mode_reg;
        cont_next = cont_reg;
        act_next = act_reg;
        lspd_next = lspd_reg;
        ltrq_next = ltrq_reg;
        lproc_next = lproc_reg;
        fb1_next = fb1_reg;
        fb2_next = fb2_reg;
        fblog_next = fblog_reg;
        if (wr && PADDR == ADDR_LCFG) begin
            force_next = PWDATA[LCFG_FORCE];
            mode_next = PWDATA[LCFG_MODE_LSB +: 2];
            cont_next = PWDATA[LCFG_CONT];
            act_next = PWDATA[LCFG_ACT_LSB +: 2];
        end
        if (wr && PADDR == ADDR_LSRC) begin
            lspd_next = PWDATA[LSRC_SPD_LSB +: 3];
            ltrq_next = PWDATA[LSRC_TRQ_LSB +: 3];
            lproc_next = PWDATA[LSRC_PROC_LSB +: 3];
        end
        if (wr && PADDR == ADDR_FBSPD) begin
            fb1_next = PWDATA[FB_SRC1_LSB +: 3];
            fb2_next = PWDATA[FB_SRC2_LSB +: 3];
            fblog_next = PWDATA[FB_LOG_LSB +: 4];
        end
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            force_reg <= RST_FORCE;
            mode_reg <= RST_MODE;
            cont_reg <= RST_CONT;
            act_reg <= RST_ACT;
            lspd_reg <= RST_LSRC;
            ltrq_reg <= RST_LSRC;
            lproc_reg <= RST_LSRC;
            fb1_reg <= RST_FB1;
            fb2_reg <= RST_FB2;
            fblog_reg <= RST_FBLOG;
        end else begin
            force_reg <= force_next;
            mode_reg <= mode_next;
            cont_reg <= cont_next;
            act_reg <= act_next;
            lspd_reg <= lspd_next;
            ltrq_reg <= ltrq_next;
            lproc_reg <= lproc_next;
            fb1_reg <= fb1_next;
            fb2_reg <= fb2_next;
            fblog_reg <= fblog_next;
        end
    end

    // panel button edges and stop qualification
    assign is_local = (place_reg == PLACE_LOCAL);
    assign is_fb = (place_reg == PLACE_FB);
    assign stop_edge = PANEL_STOP_BTN & ~stop_prev_reg;
    assign start_edge = PANEL_START_BTN & ~start_prev_reg;
    assign stop_acts = stop_edge & (is_local | force_reg);
    assign force_local = stop_edge & force_reg & ~is_local & (mode_reg != MODE_DENY_CTRL);
    assign place_req = PWDATA[PLACE_LSB +: 3];
    assign place_ok = (place_req >= PLACE_LOCAL) && (place_req <= PLACE_ADV)
                      && !(place_req == PLACE_LOCAL && mode_reg == MODE_DENY_CTRL);

    // control place and run state
    always_comb begin
        place_next = place_reg;
        if (force_local) begin
            place_next = PLACE_LOCAL;
        end else if (wr && PADDR == ADDR_PLACE && place_ok) begin
            place_next = place_req;
        end
        enter_local = (place_next == PLACE_LOCAL) && !is_local;
        local_next = (place_next == PLACE_LOCAL);
        if (stop_acts) begin
            run_next = 1'b0;
        end else if (enter_local) begin
            run_next = run_reg & cont_reg;
        end else if (is_local) begin
            run_next = run_reg | (start_edge & (mode_reg == MODE_ALLOW));
        end else begin
            run_next = REMOTE_RUN;
        end
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            place_reg <= RST_PLACE;
            local_reg <= 1'b0;
            run_reg <= 1'b0;
            stop_prev_reg <= 1'b0;
            start_prev_reg <= 1'b0;
        end else begin
            place_reg <= place_next;
            local_reg <= local_next;
            run_reg <= run_next;
            stop_prev_reg <= PANEL_STOP_BTN;
            start_prev_reg <= PANEL_START_BTN;
        end
    end

    // stop unit hookup; a new run clears stop or coast
    assign sif.act = stop_acts;
    assign sif.held = PANEL_STOP_BTN;
    assign sif.clear = run_next & ~run_reg;
    assign sif.action = act_reg;

    lfr_stop_unit #(
        .HOLD_CYCLES(HOLD_CYCLES)
    ) u_stop (
        .clk(REF_CLK),
        .rst_n(RSTN),
        .sif(sif)
    );

    // fieldbus speed sources, none and panel give zero
    assign rif.a = (fb1_reg == SRC_PANEL) ? '0 : pick_src(SPD_SRC_IN, fb1_reg);
    assign rif.b = (fb2_reg == SRC_PANEL) ? '0 : pick_src(SPD_SRC_IN, fb2_reg);
    assign rif.mode = fblog_reg;
    assign rif.toggle = FB_TOGGLE_IN;

    lfr_ref_comb u_comb (
        .rif(rif)
    );

    // reference outputs per active place
    always_comb begin
        spd_next = '0;
        trq_next = '0;
        proc_next = '0;
        if (is_local) begin
            spd_next = pick_src(SPD_SRC_IN, lspd_reg);
            trq_next = pick_src(TRQ_SRC_IN, ltrq_reg);
            proc_next = pick_src(PROC_SRC_IN, lproc_reg);
        end else if (is_fb) begin
            spd_next = rif.y;
        end
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            spd_reg <= '0;
            trq_reg <= '0;
            proc_reg <= '0;
        end else begin
            spd_reg <= spd_next;
            trq_reg <= trq_next;
            proc_reg <= proc_next;
        end
    end

    assign PRDATA = prdata_reg;
    assign PREADY = pready_reg;
    assign PSLVERR = pslverr_reg;
    assign RUN_CMD = run_reg;
    assign STOP_CMD = sif.stopping;
    assign COAST_CMD = sif.coasting;
    assign ACTIVE_PLACE = place_reg;
    assign LOCAL_ACTIVE = local_reg;
    assign SPEED_REF = spd_reg;
    assign TORQUE_REF = trq_reg;
    assign PROCESS_REF = proc_reg;

    assign panel_spd = SPD_SRC_IN[REF_W-1:0];
    assign panel_trq = TRQ_SRC_IN[REF_W-1:0];

    a_force_stop:
        assert property (@(posedge REF_CLK) disable iff (!RSTN)
            stop_edge && force_reg |=> !RUN_CMD)
        else $error("panel stop with force stop left the drive running");

    a_force_local:
        assert property (@(posedge REF_CLK) disable iff (!RSTN)
            force_local |=> ACTIVE_PLACE == PLACE_LOCAL && LOCAL_ACTIVE)
        else $error("force stop did not select local control");

    a_deny_start:
        assert property (@(posedge REF_CLK) disable iff (!RSTN)
            is_local && mode_reg != MODE_ALLOW && !run_reg |=> !RUN_CMD)
        else $error("panel start taken while denied");

    a_keep_run:
        assert property (@(posedge REF_CLK) disable iff (!RSTN)
            enter_local && !stop_acts && run_reg |=> RUN_CMD == $past(cont_reg))
        else $error("run state across change to local is wrong");

    a_local_speed:
        assert property (@(posedge REF_CLK) disable iff (!RSTN)
            is_local && lspd_reg == SRC_PANEL |=> SPEED_REF == $past(panel_spd))
        else $error("local speed reference not from panel");

    a_local_torque:
        assert property (@(posedge REF_CLK) disable iff (!RSTN)
            is_local && ltrq_reg == SRC_PANEL |=> TORQUE_REF == $past(panel_trq))
        else $error("local torque reference not from panel");

    a_div_zero:
        assert property (@(posedge REF_CLK) disable iff (!RSTN)
            is_fb && fblog_reg == COMB_DIV && rif.b == '0 |=> SPEED_REF == '0)
        else $error("divide by zero source did not give zero");

    a_fb_toggle:
        assert property (@(posedge REF_CLK) disable iff (!RSTN)
            is_fb && fblog_reg == COMB_TOGGLE |=> SPEED_REF == $past(FB_TOGGLE_IN ? rif.b : rif.a))
        else $error("toggle chose the wrong speed source");

    a_other_zero:
        assert property (@(posedge REF_CLK) disable iff (!RSTN)
            !is_local && !is_fb |=> SPEED_REF == '0 && TORQUE_REF == '0 && PROCESS_REF == '0)
        else $error("references driven outside local and fieldbus control");
endmodule

// *** verification/lfr_src_model.sv ***
// reference sources seen from panel, fieldbus and i/o side
module lfr_src_model
    import lfr_pkg::*;
(
    output logic [SRC_BUS_W-1:0] spd,
    output logic [SRC_BUS_W-1:0] trq,
    output logic [SRC_BUS_W-1:0] prc
);
    timeunit 1ns;
    timeprecision 1ps;
    // distinct value per code and per bus to expose crossed slices
    always_comb begin
        for (int k = 0; k < NSRC; k++) begin
            spd[16*k+:16] = 16'(4 * (k + 1));
            trq[16*k+:16] = 16'h100 + 16'(4 * (k + 1));
            prc[16*k+:16] = 16'h200 + 16'(4 * (k + 1));
        end
    end
endmodule

// *** verification/testbench.sv ***
module testbench
    import lfr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HC = 20;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, e;
    logic [11:0] pa = 12'h000;
    logic [31:0] pwd = 32'h0, prd, rdv;
    logic prdy, perr, stp = 0, sta = 0, rr = 0, tg = 0, run, stc, cst, loc;
    logic [2:0] plc;
    logic signed [REF_W-1:0] sr, tr, pr;
    logic [SRC_BUS_W-1:0] sb, tb, pb;
    int mismatches = 0, total_checks = 0;
    int x[9] = '{20, 8, 28, 12, 2, 160, 20, 8, 20};
    // free running clock
    always #2.5 clk = ~clk;
    lfr_src_model i_src (.spd(sb), .trq(tb), .prc(pb));
    lfr_top #(.HOLD_CYCLES(HC)) i_dut (.REF_CLK(clk), .RSTN(rst_n), .PSEL(psel),
        .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd),
        .PREADY(prdy), .PSLVERR(perr), .PANEL_STOP_BTN(stp), .PANEL_START_BTN(sta),
        .REMOTE_RUN(rr), .FB_TOGGLE_IN(tg), .SPD_SRC_IN(sb), .TRQ_SRC_IN(tb),
        .PROC_SRC_IN(pb), .RUN_CMD(run), .STOP_CMD(stc), .COAST_CMD(cst),
        .ACTIVE_PLACE(plc), .LOCAL_ACTIVE(loc), .SPEED_REF(sr), .TORQUE_REF(tr),
        .PROCESS_REF(pr));
    task chk(input logic [31:0] s, input logic [31:0] v);
        total_checks++;
        if (s !== v) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, v);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // one apb transfer, held until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk iff prdy === 1'b1);
        rdv = prd;
        e = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] v);
        apb(1'b0, a, 32'h0);
        chk(rdv, v);
    endtask
    function automatic logic [31:0] cf(input logic f, input logic [1:0] m,
        input logic c, input logic [1:0] a);
        return {26'h0, a, c, m, f};
    endfunction
    function automatic logic [31:0] rv(input logic [15:0] b, input int c);
        return {16'h0, b + 16'(4 * c)};
    endfunction
    task start_btn;
        @(posedge clk);
        sta <= 1'b1;
        cyc(2);
        @(posedge clk);
        sta <= 1'b0;
        cyc(2);
    endtask
    task stop_pulse;
        @(posedge clk);
        stp <= 1'b1;
        cyc(3);
        @(posedge clk);
        stp <= 1'b0;
        cyc(2);
    endtask
    task t_reset;
        rd(ADDR_PLACE, 32'h4);
        rd(ADDR_LCFG, 32'h29);
        rd(ADDR_LSRC, 32'h111);
        rd(ADDR_FBSPD, 32'h2);
        rd(12'h020, 32'h0);
        chk({31'h0, e}, 32'h1);
        chk({16'h0, sr}, 32'h0);
    endtask
    task t_local;
        apb(1'b1, ADDR_PLACE, 32'h1);
        apb(1'b1, ADDR_LSRC, 32'h235);
        cyc(3);
        chk({31'h0, loc}, 32'h1);
        chk({16'h0, sr}, rv(16'h0, 5));
        chk({16'h0, tr}, rv(16'h100, 3));
        chk({16'h0, pr}, rv(16'h200, 2));
    endtask
    // sources 5 and 2 give 20 and 8
    task t_fb;
        apb(1'b1, ADDR_PLACE, 32'h2);
        for (int m = 0; m < 9; m++) begin
            apb(1'b1, ADDR_FBSPD, {20'h0, 4'(m), 8'h25});
            cyc(3);
            chk({16'h0, sr}, 32'(x[m]));
        end
        @(posedge clk);
        tg <= 1'b1;
        cyc(3);
        chk({16'h0, sr}, 32'h8);
        chk({16'h0, tr}, 32'h0);
        apb(1'b1, ADDR_FBSPD, 32'h402);
        cyc(3);
        chk({16'h0, sr}, 32'h0);
        @(posedge clk);
        tg <= 1'b0;
    endtask
    task t_hold;
        rr <= 1'b1;
        cyc(3);
        chk({31'h0, run}, 32'h1);
        @(posedge clk);
        stp <= 1'b1;
        cyc(2);
        chk({29'h0, run, stc, cst}, 32'h2);
        chk({29'h0, plc}, 32'h1);
        cyc(HC - 4);
        chk({31'h0, cst}, 32'h0);
        cyc(4);
        chk({30'h0, stc, cst}, 32'h1);
        @(posedge clk);
        stp <= 1'b0;
        start_btn;
        chk({31'h0, run}, 32'h1);
        rd(ADDR_STATUS, 32'h11);
        apb(1'b1, ADDR_LSRC, 32'h111);
        cyc(2);
        chk({16'h0, sr}, rv(16'h0, 1));
        chk({16'h0, tr}, rv(16'h100, 1));
    endtask
    task t_modes;
        for (int a = 0; a < 2; a++) begin
            apb(1'b1, ADDR_LCFG, cf(1'b1, 2'h0, 1'b1, 2'(a)));
            start_btn;
            stop_pulse;
            chk({29'h0, run, stc, cst}, 32'(a == 0 ? 2 : 1));
        end
        apb(1'b1, ADDR_LCFG, cf(1'b1, 2'h1, 1'b1, 2'h0));
        start_btn;
        chk({31'h0, run}, 32'h0);
        for (int c = 1; c >= 0; c--) begin
            apb(1'b1, ADDR_LCFG, cf(1'b0, 2'h0, 1'(c), 2'h0));
            apb(1'b1, ADDR_PLACE, 32'h2);
            cyc(3);
            apb(1'b1, ADDR_PLACE, 32'h1);
            cyc(2);
            chk({31'h0, run}, 32'(c));
        end
        apb(1'b1, ADDR_PLACE, 32'h2);
        stop_pulse;
        chk({28'h0, run, plc}, 32'ha);
        @(posedge clk);
        rr <= 1'b0; // remote run off, else it restarts and clears the stop
        apb(1'b1, ADDR_LCFG, cf(1'b1, 2'h2, 1'b1, 2'h0));
        stop_pulse;
        chk({28'h0, stc, plc}, 32'ha);
        apb(1'b1, ADDR_PLACE, 32'h1);
        rd(ADDR_PLACE, 32'h2);
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_local;
        t_fb;
        t_hold;
        t_modes;
        close_out;
    end
    // watchdog well past the expected run length
    initial begin
        #100000;
        mismatches++;
        close_out;
    end
endmodule
